/* File: dv/fsps_tb.sv */
// Self-checking testbench of the flash self-program sequencer
`timescale 1ns/1ps
`include "fsps_cfg.svh"
module tb;
    // Short operation time keeps the run brief; the stall-length waits derive from it
    localparam int NOP_C = 8;

    logic                                  clk_i;
    logic                                  rst_n_i;
    logic                                  instr_valid_i;
    logic [`FSPS_ADDR_W-1:0]               addr_i;
    logic [`FSPS_WORD_W-1:0]               data_i;
    logic                                  data_wr_i;
    logic                                  unlock_wr_i;
    logic [7:0]                            unlock_data_i;
    logic                                  config_space_select_i;
    logic                                  program_space_select_i;
    logic                                  write_enable_bit_i;
    logic                                  latch_load_only_i;
    logic                                  erase_sel_set_i;
    logic                                  erase_sel_clr_i;
    logic                                  rd_set_i;
    logic                                  wr_set_i;
    logic [1:0]                            self_write_protect_field_i;
    logic                                  code_protect_bit_i;
    logic [`FSPS_WORD_W-1:0]               flash_rdata_i;
    logic [`FSPS_WORD_W-1:0]               data_o;
    logic                                  erase_sel_o;
    logic                                  rd_bit_o;
    logic                                  wr_bit_o;
    logic                                  cpu_stall_o;
    logic                                  ignore_slot_o;
    logic                                  flash_rd_o;
    logic                                  flash_erase_o;
    logic                                  flash_prog_o;
    logic [`FSPS_ADDR_W-1:0]               flash_addr_o;
    logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] flash_wdata_o;
    logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] exp_w;
    int                                    n_errors;
    int                                    n_checks;

    fsps_sequencer #(.OP_CYCLES(NOP_C)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .addr_i(addr_i),
        .data_i(data_i), .data_wr_i(data_wr_i), .unlock_wr_i(unlock_wr_i),
        .unlock_data_i(unlock_data_i), .config_space_select_i(config_space_select_i),
        .program_space_select_i(program_space_select_i),
        .write_enable_bit_i(write_enable_bit_i), .latch_load_only_i(latch_load_only_i),
        .erase_sel_set_i(erase_sel_set_i), .erase_sel_clr_i(erase_sel_clr_i),
        .rd_set_i(rd_set_i), .wr_set_i(wr_set_i),
        .self_write_protect_field_i(self_write_protect_field_i),
        .code_protect_bit_i(code_protect_bit_i), .flash_rdata_i(flash_rdata_i),
        .data_o(data_o), .erase_sel_o(erase_sel_o), .rd_bit_o(rd_bit_o), .wr_bit_o(wr_bit_o),
        .cpu_stall_o(cpu_stall_o), .ignore_slot_o(ignore_slot_o), .flash_rd_o(flash_rd_o),
        .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o),
        .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o));

    // Free-running 50 MHz instruction clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Compare one value, count it, report a difference at once
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One executed instruction; strobes last exactly one cycle
    task automatic drv(input logic ul, input logic [7:0] ud, input logic ws, input logic rs,
                       input logic dw, input logic es, input logic [`FSPS_WORD_W-1:0] d);
        @(posedge clk_i);
        instr_valid_i   <= 1'b1;
        unlock_wr_i     <= ul;
        unlock_data_i   <= ud;
        wr_set_i        <= ws;
        rd_set_i        <= rs;
        data_wr_i       <= dw;
        erase_sel_set_i <= es;
        if (dw) data_i <= d;
    endtask

    // Empty slot; returns at the edge that sampled the last instruction
    task automatic idle();
        @(posedge clk_i);
        {instr_valid_i, unlock_wr_i, wr_set_i, rd_set_i, data_wr_i, erase_sel_set_i} <= '0;
    endtask

    // Move n edges on and let their updates land
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    // Unlock then trigger: 0 proper, 1 stray instruction inside, 2 codes swapped
    task automatic trig(input int m);
        drv(1'b1, (m == 2) ? `FSPS_UNLOCK_SECOND : `FSPS_UNLOCK_FIRST, 0, 0, 0, 0, 14'h0000);
        if (m == 1) drv(1'b0, 8'h00, 0, 0, 0, 0, 14'h0000);
        drv(1'b1, (m == 2) ? `FSPS_UNLOCK_FIRST : `FSPS_UNLOCK_SECOND, 0, 0, 0, 0, 14'h0000);
        drv(1'b0, 8'h00, 1, 0, 0, 0, 14'h0000);
        idle();
    endtask

    // Verdict and the only end of the run
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard: the whole sequence needs far fewer cycles than this
    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        n_checks = 0;
        {instr_valid_i, data_wr_i, unlock_wr_i, erase_sel_set_i, erase_sel_clr_i} = '0;
        {rd_set_i, wr_set_i, config_space_select_i, latch_load_only_i} = '0;
        {program_space_select_i, write_enable_bit_i} = 2'b11;
        {addr_i, data_i, unlock_data_i, flash_rdata_i} = '0;
        self_write_protect_field_i = 2'h3;
        code_protect_bit_i = 1'b1;
        rst_n_i = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1'b1;
        wt(1);
        chk(flash_wdata_o, {8{`FSPS_LATCH_RST}});
        chk({data_o, wr_bit_o, cpu_stall_o, erase_sel_o}, 0);
        // Program read under code protection, then the data pair must hold
        @(posedge clk_i);
        addr_i <= 15'h0ABC;
        flash_rdata_i <= 14'h2D5A;
        drv(0, 8'h00, 0, 1, 0, 0, 14'h0000);
        idle();
        #1;
        chk(rd_bit_o, 1'b1);
        chk(flash_addr_o, 15'h0ABC);
        wt(1); chk({ignore_slot_o, flash_rd_o}, 2'b11);
        @(posedge clk_i);
        flash_rdata_i <= 14'h0000;
        #1; chk(data_o, 14'h2D5A);
        chk({rd_bit_o, ignore_slot_o}, 2'b00);
        wt(3); chk(data_o, 14'h2D5A);
        // Read with configuration space selected is ignored
        @(posedge clk_i);
        config_space_select_i <= 1'b1;
        drv(0, 8'h00, 0, 1, 0, 0, 14'h0000);
        idle();
        wt(1); chk(rd_bit_o, 1'b0);
        // Load latches 0..5 and 7; latch 6 is never loaded but still written
        exp_w = {8{`FSPS_LATCH_RST}};
        for (int i = 0; i < 8; i++) begin
            if (i == 6) continue;
            @(posedge clk_i);
            config_space_select_i <= 1'b0;
            addr_i <= 15'h1238 + 15'(i);
            latch_load_only_i <= (i != 7);
            drv(0, 8'h00, 0, 0, 1, 0, 14'h1540 + 14'(i));
            exp_w[14*i +: 14] = 14'h1540 + 14'(i);
            trig(0);
            if (i < 7) begin
                wt(3); chk({wr_bit_o, cpu_stall_o, flash_prog_o}, 3'b000);
            end
        end
        #1;
        chk(wr_bit_o, 1'b1);
        chk(flash_addr_o, 15'h1238);
        wt(1); chk(cpu_stall_o, 1'b0);
        wt(1); chk({cpu_stall_o, flash_prog_o, flash_erase_o}, 3'b110);
        chk(flash_wdata_o, exp_w);
        // A data-pair write presented during the stall must be dropped
        drv(0, 8'h00, 0, 0, 1, 0, 14'h0777);
        idle();
        wt(NOP_C - 3);
        chk({cpu_stall_o, data_o}, {1'b1, 14'h1547});
        wt(1); chk({cpu_stall_o, wr_bit_o, flash_prog_o}, 3'b000);
        chk(flash_wdata_o, {8{`FSPS_LATCH_RST}});
        // Row erase from an address inside the row
        @(posedge clk_i);
        addr_i <= 15'h1245;
        latch_load_only_i <= 1'b0;
        drv(0, 8'h00, 0, 0, 0, 1, 14'h0000);
        trig(0);
        #1;
        chk({erase_sel_o, wr_bit_o}, 2'b11);
        chk(flash_addr_o, 15'h1240);
        wt(1); chk(cpu_stall_o, 1'b0);
        wt(1); chk({cpu_stall_o, flash_erase_o, flash_prog_o}, 3'b110);
        wt(NOP_C); chk({erase_sel_o, cpu_stall_o, flash_erase_o}, 3'b000);
        // Refused triggers: enable clear, broken unlock, swapped codes, protected
        for (int m = 0; m < 4; m++) begin
            @(posedge clk_i);
            write_enable_bit_i <= (m != 0);
            self_write_protect_field_i <= (m == 3) ? `FSPS_PROT_ALL : 2'h3;
            trig((m == 1 || m == 2) ? m : 0);
            wt(1); chk(wr_bit_o, 1'b0);
            wt(2); chk({cpu_stall_o, flash_prog_o}, 2'b00);
        end
        // Software sets erase-select, then clears it again
        drv(0, 8'h00, 0, 0, 0, 1, 14'h0000);
        @(posedge clk_i);
        erase_sel_set_i <= 1'b0;
        erase_sel_clr_i <= 1'b1;
        #1;
        chk(erase_sel_o, 1'b1);
        idle();
        erase_sel_clr_i <= 1'b0;
        #1;
        chk(erase_sel_o, 1'b0);
        end_sim();
    end
endmodule // tb

/* File: include/fsps_cfg.svh */
// Constants of the flash self-program sequencer: geometry, codes, timing
`ifndef FSPS_CFG_SVH
`define FSPS_CFG_SVH

`define FSPS_ADDR_W        15
`define FSPS_WORD_W        14
`define FSPS_ROW_LSB       5
`define FSPS_BLK_LSB       3
`define FSPS_LATCHES       8
`define FSPS_LATCH_RST     14'h3FFF
`define FSPS_UNLOCK_FIRST  8'h55
`define FSPS_UNLOCK_SECOND 8'hAA
`define FSPS_TIMER_W       17
`define FSPS_CLK_NS        20
`define FSPS_T_OP_NS       2000000
`define FSPS_PROT_ALL      2'h0
`define FSPS_PROT_HALF     2'h1
`define FSPS_PROT_BOOT     2'h2
`define FSPS_PROT_LIM_HALF 15'h1000
`define FSPS_PROT_LIM_BOOT 15'h0200

`endif

/* File: include/fsps_pkg.sv */
// Types of the flash self-program sequencer
`include "fsps_cfg.svh"
package fsps_pkg;
    typedef enum logic [1:0] {
        FSPS_UL_IDLE = 2'b00,
        FSPS_UL_55   = 2'b01,
        FSPS_UL_AA   = 2'b10
    } fsps_unlock_t;

    typedef enum logic [2:0] {
        FSPS_OP_IDLE   = 3'b000,
        FSPS_OP_RDWAIT = 3'b001,
        FSPS_OP_RDSLOT = 3'b010,
        FSPS_OP_SETUP1 = 3'b011,
        FSPS_OP_SETUP2 = 3'b100,
        FSPS_OP_BUSY   = 3'b101
    } fsps_op_t;

    typedef struct packed {
        fsps_unlock_t                                     unlock;
        fsps_op_t                                         op;
        logic                                             erase_sel;
        logic                                             is_erase;
        logic                                             rd_bit;
        logic                                             wr_bit;
        logic                                             stall;
        logic                                             ignore_slot;
        logic                                             flash_rd;
        logic                                             flash_erase;
        logic                                             flash_prog;
        logic [`FSPS_TIMER_W-1:0]                         timer;
        logic [`FSPS_WORD_W-1:0]                          data;
        logic [`FSPS_ADDR_W-1:0]                          op_addr;
        logic [`FSPS_LATCHES-1:0][`FSPS_WORD_W-1:0]       latch;
    } fsps_state_t;
endpackage

/* File: logic/fsps_sequencer.sv */
// Flash self-program sequencer: read, row erase, latch load and block write
`timescale 1ns/1ps
`include "fsps_cfg.svh"
// Overview of operation
// - Flash rows hold 32 words of 14 bits, row-aligned; erase acts on one row.
// - Erase or program of a write-protected segment is refused.
// - Eight hidden 14-bit latches are filled from the data pair.
// - Latch block is 8 words aligned on 000; block write never crosses it.
// - Program read uses the second following cycle, that instruction is ignored.
// - Read word lands in the data pair next cycle and stays there.
// - Self-reads work whatever the code-protect setting.
// - Erase-select clears when the row erase finishes.
// - Erase: two setup cycles, then execution halts about 2 ms.
// - After a stall execution resumes at the third instruction after trigger.
// - Programming never erases anything first.
// - Latch-load-only trigger with erase-select clear just stores the data pair, no program, no stall.
// - Otherwise, with erase-select clear, trigger loads last latch and programs all 8 latches.
// - Block write and row erase each stall about 2 ms, latch loads do not.
// - After a program write every latch returns to 3FFFh.
// - Read and write triggers only set by software, cleared by hardware.
// - Write trigger cannot set while write enable is clear.
// - No write or erase without 55h then AAh right before the trigger.

module fsps_sequencer #(
    parameter int OP_CYCLES = `FSPS_T_OP_NS / `FSPS_CLK_NS
) (
    input  wire logic                       clk_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       instr_valid_i,
    input  wire logic [`FSPS_ADDR_W-1:0]    addr_i,
    input  wire logic [`FSPS_WORD_W-1:0]    data_i,
    input  wire logic                       data_wr_i,
    input  wire logic                       unlock_wr_i,
    input  wire logic [7:0]                 unlock_data_i,
    input  wire logic                       config_space_select_i,
    input  wire logic                       program_space_select_i,
    input  wire logic                       write_enable_bit_i,
    input  wire logic                       latch_load_only_i,
    input  wire logic                       erase_sel_set_i,
    input  wire logic                       erase_sel_clr_i,
    input  wire logic                       rd_set_i,
    input  wire logic                       wr_set_i,
    input  wire logic [1:0]                 self_write_protect_field_i,
    input  wire logic                       code_protect_bit_i,
    input  wire logic [`FSPS_WORD_W-1:0]    flash_rdata_i,
    output logic [`FSPS_WORD_W-1:0]         data_o,
    output logic                            erase_sel_o,
    output logic                            rd_bit_o,
    output logic                            wr_bit_o,
    output logic                            cpu_stall_o,
    output logic                            ignore_slot_o,
    output logic                            flash_rd_o,
    output logic                            flash_erase_o,
    output logic                            flash_prog_o,
    output logic [`FSPS_ADDR_W-1:0]         flash_addr_o,
    output logic [`FSPS_LATCHES*`FSPS_WORD_W-1:0] flash_wdata_o
);

    localparam logic [`FSPS_TIMER_W-1:0] OP_LOAD = `FSPS_TIMER_W'(OP_CYCLES);

    fsps_pkg::fsps_state_t st_reg;
    fsps_pkg::fsps_state_t st_next;
    logic                  instr_ok;
    logic                  space_ok;
    logic                  prot_hit;
    logic                  accept_rd;
    logic                  accept_wr;

    // Protection compares the target against the low protected segment
    function automatic logic fsps_protected(input logic [1:0] wrt,
                                            input logic [`FSPS_ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (wrt == `FSPS_PROT_ALL) begin
            hit = 1'b1;
        end else if (wrt == `FSPS_PROT_HALF) begin
            hit = (a < `FSPS_PROT_LIM_HALF);
        end else if (wrt == `FSPS_PROT_BOOT) begin
            hit = (a < `FSPS_PROT_LIM_BOOT);
        end
        return hit;
    endfunction

    // Halted slots and the slot borrowed by a read are no-ops, so nothing counts then
    assign instr_ok  = instr_valid_i & ~st_reg.stall & ~st_reg.ignore_slot;
    assign space_ok  = program_space_select_i & ~config_space_select_i;
    assign prot_hit  = fsps_protected(self_write_protect_field_i, addr_i);
    // Code protection deliberately plays no part in self-reads
    assign accept_rd = instr_ok & rd_set_i & space_ok & ~st_reg.rd_bit
                     & (st_reg.op == fsps_pkg::FSPS_OP_IDLE);
    assign accept_wr = instr_ok & wr_set_i & space_ok & write_enable_bit_i
                     & (st_reg.unlock == fsps_pkg::FSPS_UL_AA)
                     & ~prot_hit & (st_reg.op == fsps_pkg::FSPS_OP_IDLE);

    // Next-state logic for the whole sequencer
    always_comb begin
        st_next             = st_reg;
        st_next.ignore_slot = 1'b0;
        st_next.flash_rd    = 1'b0;

        // Software writes to the data pair and the erase-select bit
        if (instr_ok && data_wr_i) begin
            st_next.data = data_i;
        end
        if (instr_ok && erase_sel_set_i) begin
            st_next.erase_sel = 1'b1;
        end else if (instr_ok && erase_sel_clr_i) begin
            st_next.erase_sel = 1'b0;
        end

        // Unlock tracker: only 55h, AAh, trigger on adjacent instructions survive
        if (instr_ok) begin
            unique case (st_reg.unlock)
                fsps_pkg::FSPS_UL_IDLE: begin
                    st_next.unlock = (unlock_wr_i && unlock_data_i == `FSPS_UNLOCK_FIRST)
                                   ? fsps_pkg::FSPS_UL_55 : fsps_pkg::FSPS_UL_IDLE;
                end
                fsps_pkg::FSPS_UL_55: begin
                    if (unlock_wr_i && unlock_data_i == `FSPS_UNLOCK_SECOND) begin
                        st_next.unlock = fsps_pkg::FSPS_UL_AA;
                    end else if (unlock_wr_i && unlock_data_i == `FSPS_UNLOCK_FIRST) begin
                        st_next.unlock = fsps_pkg::FSPS_UL_55;
                    end else begin
                        st_next.unlock = fsps_pkg::FSPS_UL_IDLE;
                    end
                end
                default: begin
                    st_next.unlock = fsps_pkg::FSPS_UL_IDLE;
                end
            endcase
        end

        unique case (st_reg.op)
            fsps_pkg::FSPS_OP_IDLE: begin
                if (accept_rd) begin
                    st_next.rd_bit  = 1'b1;
                    st_next.op_addr = addr_i;
                    st_next.op      = fsps_pkg::FSPS_OP_RDWAIT;
                end else if (accept_wr && latch_load_only_i && !st_reg.erase_sel) begin
                    // Latch load finishes at once, so the trigger never shows set
                    st_next.latch[addr_i[`FSPS_BLK_LSB-1:0]] = st_next.data;
                end else if (accept_wr) begin
                    st_next.wr_bit   = 1'b1;
                    st_next.is_erase = st_reg.erase_sel;
                    st_next.op       = fsps_pkg::FSPS_OP_SETUP1;
                    if (st_reg.erase_sel) begin
                        st_next.op_addr = {addr_i[`FSPS_ADDR_W-1:`FSPS_ROW_LSB],
                                           `FSPS_ROW_LSB'(0)};
                    end else begin
                        st_next.latch[addr_i[`FSPS_BLK_LSB-1:0]] = st_next.data;
                        st_next.op_addr = {addr_i[`FSPS_ADDR_W-1:`FSPS_BLK_LSB],
                                           `FSPS_BLK_LSB'(0)};
                    end
                end
            end
            fsps_pkg::FSPS_OP_RDWAIT: begin
                // Next cycle is the borrowed slot: flash access, instruction dropped
                st_next.ignore_slot = 1'b1;
                st_next.flash_rd    = 1'b1;
                st_next.op          = fsps_pkg::FSPS_OP_RDSLOT;
            end
            fsps_pkg::FSPS_OP_RDSLOT: begin
                st_next.data   = flash_rdata_i;
                st_next.rd_bit = 1'b0;
                st_next.op     = fsps_pkg::FSPS_OP_IDLE;
            end
            fsps_pkg::FSPS_OP_SETUP1: begin
                st_next.op = fsps_pkg::FSPS_OP_SETUP2;
            end
            fsps_pkg::FSPS_OP_SETUP2: begin
                // Erase or program is a single pulse; no implicit erase before program
                st_next.op          = fsps_pkg::FSPS_OP_BUSY;
                st_next.stall       = 1'b1;
                st_next.timer       = OP_LOAD;
                st_next.flash_erase = st_reg.is_erase;
                st_next.flash_prog  = ~st_reg.is_erase;
            end
            fsps_pkg::FSPS_OP_BUSY: begin
                if (st_reg.timer <= `FSPS_TIMER_W'(1)) begin
                    // Release leaves the fetch on the third instruction after trigger
                    st_next.op          = fsps_pkg::FSPS_OP_IDLE;
                    st_next.stall       = 1'b0;
                    st_next.flash_erase = 1'b0;
                    st_next.flash_prog  = 1'b0;
                    st_next.wr_bit      = 1'b0;
                    if (st_reg.is_erase) begin
                        st_next.erase_sel = 1'b0;
                    end else begin
                        for (int i = 0; i < `FSPS_LATCHES; i++) begin
                            st_next.latch[i] = `FSPS_LATCH_RST;
                        end
                    end
                end else begin
                    st_next.timer = st_reg.timer - `FSPS_TIMER_W'(1);
                end
            end
            default: begin
                st_next.op = fsps_pkg::FSPS_OP_IDLE;
            end
        endcase
    end

    // State register; latches come out of reset erased-blank
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg         <= '0;
            st_reg.unlock  <= fsps_pkg::FSPS_UL_IDLE;
            st_reg.op      <= fsps_pkg::FSPS_OP_IDLE;
            st_reg.latch   <= {`FSPS_LATCHES{`FSPS_LATCH_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output is a field of the state register
    assign data_o        = st_reg.data;
    assign erase_sel_o   = st_reg.erase_sel;
    assign rd_bit_o      = st_reg.rd_bit;
    assign wr_bit_o      = st_reg.wr_bit;
    assign cpu_stall_o   = st_reg.stall;
    assign ignore_slot_o = st_reg.ignore_slot;
    assign flash_rd_o    = st_reg.flash_rd;
    assign flash_erase_o = st_reg.flash_erase;
    assign flash_prog_o  = st_reg.flash_prog;
    assign flash_addr_o  = st_reg.op_addr;
    assign flash_wdata_o = st_reg.latch;

    // Checks on the sequencer's own outputs
    a_rd_slot_nop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        accept_rd |=> !ignore_slot_o ##1 (ignore_slot_o && flash_rd_o) ##1 !rd_bit_o)
        else $error("read slot not on second cycle");
    a_rd_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flash_rd_o |=> data_o == $past(flash_rdata_i))
        else $error("read word not captured");
    a_wr_needs_write_enable_bit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(wr_bit_o) |-> $past(write_enable_bit_i) && $past(wr_set_i))
        else $error("write trigger set without enable");
    a_wr_unlocked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(wr_bit_o) |-> $past(st_reg.unlock) == fsps_pkg::FSPS_UL_AA)
        else $error("write trigger set without unlock");
    a_prot_refuse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (st_reg.op == fsps_pkg::FSPS_OP_IDLE && prot_hit) |=> !wr_bit_o)
        else $error("protected segment accepted");
    a_load_no_stall: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (accept_wr && latch_load_only_i && !erase_sel_o) |=> (!cpu_stall_o && !wr_bit_o)[*3])
        else $error("latch load stalled");
    a_stall_setup: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(wr_bit_o) |-> !cpu_stall_o ##1 !cpu_stall_o ##1 cpu_stall_o)
        else $error("stall not after two setup cycles");
    a_blk_align: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flash_prog_o |-> flash_addr_o[`FSPS_BLK_LSB-1:0] == '0)
        else $error("block write misaligned");
    a_row_align: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        flash_erase_o |-> flash_addr_o[`FSPS_ROW_LSB-1:0] == '0)
        else $error("row erase misaligned");
    a_erase_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(flash_erase_o) |-> !erase_sel_o && !wr_bit_o && !cpu_stall_o)
        else $error("erase completion not flagged");
    a_latch_blank: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $fell(flash_prog_o) |-> flash_wdata_o == {`FSPS_LATCHES{`FSPS_LATCH_RST}})
        else $error("latches not reset after write");

endmodule // fsps_sequencer
